// file: odsl_loader.sv
// Serial loader, input and converter latches and switch decode of an octal converter
`timescale 1ns/10ps
// Summary of operation
// - Shift data in on serial clock falling edges
// - Frame sync low frames a word; shift only then
// - Sixteenth edge passes data through a two-entry buffer to the selected input latch
// - Words are 16 bits, data MSB first
// - Address bit mismatch with strap discards word
// - Last three bits select channel A to H
// - Shift register drives serial data output
// - Output echoes data regardless of address match
// - Load strobe low updates all converter latches
// - Clear low forces all converter latches zero
// - Top two bits drive three segment switches
// - Lower ten bits drive ladder switches directly
// - After sixteen bits, wait for next frame start
// - Output launched on following serial clock rise
// - Clear leaves input latches untouched
module odsl_loader
    import odsl_pkg::*;
#(
    parameter int ADDR_W = 8
)(
    // Clock and reset
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    // APB register port
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [ADDR_W-1:0]            paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    // Serial link
    input  wire logic                         serial_clock_in,
    input  wire logic                         frame_sync_n,
    input  wire logic                         serial_data_in,
    output logic                              serial_data_out,
    // Strap and asynchronous controls
    input  wire logic                         device_addr_strap,
    input  wire logic                         load_all_n,
    input  wire logic                         zero_outputs_n,
    // Converter switch drive
    output logic      [CHANS*SEG_SW-1:0]      seg_switch,
    output logic      [CHANS*LADDER_BITS-1:0] ladder_switch,
    output logic      [CHANS*DATA_BITS-1:0]   dac_code
);

    logic [SYNC_LANES-1:0]             sync_meta;
    logic [SYNC_LANES-1:0]             sync_q;
    logic                              sclk_prev;
    logic                              fs_prev;
    logic                              sclk_s;
    logic                              fs_s;
    logic                              sdi_s;
    logic                              strap_s;
    logic                              load_s;
    logic                              clr_s;
    logic                              sclk_fall;
    logic                              sclk_rise;
    logic                              fs_fall;
    odsl_frame_t                       state;
    logic [3:0]                        bit_cnt;
    logic [3:0]                        cnt_cur;
    logic [WORD_BITS-1:0]              shreg;
    logic [WORD_BITS-1:0]              next_shreg;
    logic                              shift_en;
    logic                              word_done;
    logic                              addr_ok;
    logic                              chan_sel_bit2;
    logic                              chan_sel_bit1;
    logic                              chan_sel_bit0;
    logic [FIFO_W-1:0]                 fifo_mem [2];
    logic                              wr_ptr;
    logic                              rd_ptr;
    logic [1:0]                        fifo_cnt;
    logic                              fifo_in_ready;
    logic                              fifo_out_valid;
    logic                              drain_ready;
    logic                              push;
    logic                              pop;
    logic [FIFO_W-1:0]                 fifo_head;
    logic [CHANS-1:0][DATA_BITS-1:0]   in_lat;
    logic [CHANS-1:0][DATA_BITS-1:0]   dac_lat;
    logic                              ctrl_freeze;
    logic                              sw_load;
    logic                              st_ovf;
    logic                              st_miss;
    logic [15:0]                       word_count;
    logic                              apb_setup;
    logic                              apb_wr;
    logic                              err_q;
    logic [31:0]                       rd_mux;
    logic                              rd_hit;
    logic [7:0]                        addr8;

    // Every input pin except clock, reset and the APB port crosses two flops; only the second stage is read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_meta <= '1;
            sync_q    <= '1;
            sclk_prev <= 1'b1;
            fs_prev   <= 1'b1;
        end
        else
        begin
            sync_meta <= {serial_clock_in, frame_sync_n, serial_data_in,
                          device_addr_strap, load_all_n, zero_outputs_n};
            sync_q    <= sync_meta;
            sclk_prev <= sclk_s;
            fs_prev   <= fs_s;
        end
    end

    assign {sclk_s, fs_s, sdi_s, strap_s, load_s, clr_s} = sync_q;
    assign sclk_fall = sclk_prev & ~sclk_s;
    assign sclk_rise = ~sclk_prev & sclk_s;
    assign fs_fall   = fs_prev & ~fs_s;

    // A frame start in the same cycle as a clock fall counts that bit as the first
    assign cnt_cur    = fs_fall ? 4'h0 : bit_cnt;
    assign shift_en   = sclk_fall & ~fs_s & (fs_fall | (state == FR_SHIFT));
    assign next_shreg = {shreg[WORD_BITS-2:0], sdi_s};
    assign word_done  = shift_en & (cnt_cur == LAST_BIT);
    assign addr_ok    = (next_shreg[ADDR_BIT_POS] == strap_s);
    assign {chan_sel_bit2, chan_sel_bit1, chan_sel_bit0} = next_shreg[SEL_BITS-1:0];
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state   <= FR_IDLE;
            bit_cnt <= 4'h0;
            shreg   <= '0;
        end
        else if (shift_en)
        begin
            shreg   <= next_shreg;
            bit_cnt <= 4'(cnt_cur + 4'h1);
            state   <= (cnt_cur == LAST_BIT) ? FR_FULL : FR_SHIFT;
        end
        else if (fs_fall)
        begin
            state   <= FR_SHIFT;
            bit_cnt <= 4'h0;
        end
        else
        begin
            case (state)
                // Sync released mid-word abandons the partial word
                FR_SHIFT: if (fs_s) state <= FR_IDLE;
                FR_FULL:  state <= FR_FULL;
                FR_IDLE:  state <= FR_IDLE;
                default:  state <= FR_IDLE;
            endcase
        end
    end

    // Echo is independent of the address check so chains see every word
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            serial_data_out <= 1'b0;
        else if (sclk_rise)
            serial_data_out <= shreg[WORD_BITS-1];
    end

    // Two-entry word buffer between the link and the input latches
    assign fifo_in_ready  = (fifo_cnt != FIFO_DEPTH);
    assign fifo_out_valid = (fifo_cnt != 2'h0);
    assign drain_ready    = ~ctrl_freeze;
    assign push           = word_done & addr_ok & fifo_in_ready;
    assign pop            = fifo_out_valid & drain_ready;
    assign fifo_head      = fifo_mem[rd_ptr];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_ptr   <= 1'b0;
            rd_ptr   <= 1'b0;
            fifo_cnt <= 2'h0;
        end
        else
        begin
            if (push)
                wr_ptr <= ~wr_ptr;
            if (pop)
                rd_ptr <= ~rd_ptr;
            fifo_cnt <= 2'(fifo_cnt + {1'b0, push} - {1'b0, pop});
        end
    end
    always_ff @(posedge pclk)
    begin
        if (push)
            fifo_mem[wr_ptr] <= {next_shreg[WORD_BITS-1:DATA_LSB_POS],
                                 chan_sel_bit2, chan_sel_bit1, chan_sel_bit0};
    end

    // Clear never touches these, so a later load restores the old codes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            in_lat <= '0;
        else if (pop)
            in_lat[fifo_head[SEL_BITS-1:0]] <= fifo_head[FIFO_W-1:SEL_BITS];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dac_lat <= '0;
        else if (!clr_s)
            dac_lat <= '0;
        else if (!load_s || sw_load)
            dac_lat <= in_lat;
    end
    assign dac_code = dac_lat;
    function automatic logic [SEG_SW-1:0] thermo(input logic [TOP_BITS-1:0] top);
        thermo = {&top, top[1], |top};
    endfunction
    genvar g;
    generate
        for (g = 0; g < CHANS; g++)
        begin : g_chan
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    seg_switch[g*SEG_SW +: SEG_SW]           <= '0;
                    ladder_switch[g*LADDER_BITS +: LADDER_BITS] <= '0;
                end
                else
                begin
                    seg_switch[g*SEG_SW +: SEG_SW] <=
                        thermo(dac_lat[g][DATA_BITS-1 -: TOP_BITS]);
                    ladder_switch[g*LADDER_BITS +: LADDER_BITS] <=
                        dac_lat[g][LADDER_BITS-1:0];
                end
            end

            a_seg_decode: assert property (@(posedge pclk) disable iff (!presetn)
                $countones(seg_switch[g*SEG_SW +: SEG_SW]) ==
                $past(dac_lat[g][DATA_BITS-1 -: TOP_BITS]))
                else $error("segment count differs from top bits");
        end
    endgenerate

    // APB slave, zero wait states; read data is fetched in the setup cycle
    assign addr8     = paddr[7:0];
    assign apb_setup = psel & ~penable;
    assign apb_wr    = psel & penable & pwrite;
    assign pready    = 1'b1;
    assign pslverr   = psel & penable & err_q;

    always_comb
    begin
        rd_mux = 32'h0;
        rd_hit = 1'b1;
        if (addr8[7:5] == WIN_INLAT)
            rd_mux[DATA_BITS-1:0] = in_lat[addr8[4:2]];
        else if (addr8[7:5] == WIN_DACLAT)
            rd_mux[DATA_BITS-1:0] = dac_lat[addr8[4:2]];
        else
        begin
            case (addr8)
                OFF_CTRL:   rd_mux[CTRL_FREEZE] = ctrl_freeze;
                OFF_STATUS:
                begin
                    rd_mux[ST_OVF]            = st_ovf;
                    rd_mux[ST_MISS]           = st_miss;
                    rd_mux[ST_FCNT +: 2]      = fifo_cnt;
                    rd_mux[ST_FULL]           = (state == FR_FULL);
                    rd_mux[ST_STRAP]          = strap_s;
                    rd_mux[ST_BITCNT +: 4]    = bit_cnt;
                end
                OFF_COUNT:  rd_mux[15:0] = word_count;
                default:    rd_hit = 1'b0;
            endcase
        end
        if (addr8[1:0] != 2'h0)
            rd_hit = 1'b0;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0;
            err_q  <= 1'b0;
        end
        else if (apb_setup)
        begin
            prdata <= rd_hit ? rd_mux : 32'h0;
            err_q  <= ~rd_hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_freeze <= 1'b0;
            sw_load     <= 1'b0;
        end
        else
        begin
            sw_load <= apb_wr & (addr8 == OFF_CTRL) & pwdata[CTRL_LOAD];
            if (apb_wr && addr8 == OFF_CTRL)
                ctrl_freeze <= pwdata[CTRL_FREEZE];
        end
    end

    // Write one to clear; a new event in the same cycle wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ovf     <= 1'b0;
            st_miss    <= 1'b0;
            word_count <= 16'h0;
        end
        else
        begin
            st_ovf  <= (st_ovf & ~(apb_wr && addr8 == OFF_STATUS && pwdata[ST_OVF]))
                       | (word_done & addr_ok & ~fifo_in_ready);
            st_miss <= (st_miss & ~(apb_wr && addr8 == OFF_STATUS && pwdata[ST_MISS]))
                       | (word_done & ~addr_ok);
            if (push)
                word_count <= 16'(word_count + 16'h1);
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_shift_on_fall: assert property (shift_en |=> shreg == $past(next_shreg))
        else $error("shift register missed a falling edge");
    a_shift_frame_low: assert property (shift_en |-> !fs_s)
        else $error("shift while frame sync high");
    a_hold_after_word: assert property ((state == FR_FULL && !fs_fall) |=> $stable(shreg))
        else $error("shift register loaded after sixteen bits");
    a_push_on_last: assert property (push |-> sclk_fall && cnt_cur == LAST_BIT)
        else $error("word accepted on wrong edge");
    a_addr_gate: assert property ((word_done && !addr_ok) |->
        !push ##1 ($stable(fifo_cnt) || $past(pop)))
        else $error("mismatched word reached buffer");
    a_echo_launch: assert property (sclk_rise |=>
        serial_data_out == $past(shreg[WORD_BITS-1]))
        else $error("echo not launched on rising edge");
    a_echo_steady: assert property (!sclk_rise |=> $stable(serial_data_out))
        else $error("echo changed without a rising edge");
    a_load_all: assert property ((!load_s && clr_s) |=> dac_lat == $past(in_lat))
        else $error("load strobe did not copy all latches");
    a_clear_zero: assert property (!clr_s |=> dac_lat == '0 ##1 1'b1)
        else $error("clear did not zero converter latches");
    a_clear_keeps: assert property ((!clr_s && !pop) |=> $stable(in_lat))
        else $error("clear disturbed input latches");
    c_word_taken: cover property (push ##[1:20] pop);
    c_word_miss: cover property (word_done && !addr_ok);
    c_buffer_full: cover property (fifo_cnt == FIFO_DEPTH);
    c_load_then_clear: cover property (!load_s ##[1:200] !clr_s);

endmodule

// file: odsl_pkg.sv
// Constants and types shared by the octal converter serial loader
package odsl_pkg;

    // Serial word layout
    localparam int WORD_BITS = 16;
    localparam int DATA_BITS = 12;
    localparam int SEL_BITS  = 3;
    localparam int CHANS     = 8;
    localparam logic [3:0] LAST_BIT     = 4'hf;
    localparam logic [3:0] ADDR_BIT_POS = 4'h3;
    localparam int DATA_LSB_POS = 4;

    // Converter switch decode
    localparam int SEG_SW      = 3;
    localparam int TOP_BITS    = 2;
    localparam int LADDER_BITS = 10;

    // Word buffer
    localparam int FIFO_W = DATA_BITS + SEL_BITS;
    localparam logic [1:0] FIFO_DEPTH = 2'h2;

    // Input synchroniser lanes
    localparam int SYNC_LANES = 6;

    // Register byte offsets and latch windows
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_COUNT  = 8'h08;
    localparam logic [2:0] WIN_INLAT  = 3'h1;
    localparam logic [2:0] WIN_DACLAT = 3'h2;

    // Register fields
    localparam int CTRL_FREEZE = 0;
    localparam int CTRL_LOAD   = 1;
    localparam int ST_OVF      = 0;
    localparam int ST_MISS     = 1;
    localparam int ST_FCNT     = 2;
    localparam int ST_FULL     = 4;
    localparam int ST_STRAP    = 5;
    localparam int ST_BITCNT   = 8;

    typedef enum logic [1:0] {FR_IDLE, FR_SHIFT, FR_FULL} odsl_frame_t;

endpackage

// file: odsl_host_model.sv
// Host controller model driving the framed serial link
`timescale 1ns/10ps
module odsl_host_model (
    // Serial link to the device
    output logic      serial_clock_in,
    output logic      frame_sync_n,
    output logic      serial_data_in,
    input  wire logic serial_data_out
);
    // Link clock parks high between frames
    initial
    begin
        serial_clock_in = 1'b1;
        frame_sync_n    = 1'b1;
        serial_data_in  = 1'b0;
    end

    // Echo is sampled mid low half, where the device's launch has settled
    task automatic send(input logic [15:0] word, input int extra, output logic [15:0] echo);
        int i;
        #37 frame_sync_n = 1'b0;
        for (i = 15; i >= -extra; i--)
        begin
            serial_data_in = (i >= 0) ? word[i] : ~serial_data_in;
            #50 serial_clock_in = 1'b0;
            #50;
            if (i >= 0)
                echo[i] = serial_data_out;
            #50 serial_clock_in = 1'b1;
            #50;
        end
        #50 frame_sync_n = 1'b1;
        serial_data_in = ~serial_data_in;
        #200;
    endtask
endmodule

// file: odsl_loader_test.sv
// Self-checking bench for the octal converter serial loader
`timescale 1ns/10ps
module odsl_loader_test;
    import odsl_pkg::*;

    logic                         pclk;
    logic                         presetn;
    logic                         psel;
    logic                         penable;
    logic                         pwrite;
    logic [7:0]                   paddr;
    logic [31:0]                  pwdata;
    logic [31:0]                  prdata;
    logic                         pready;
    logic                         pslverr;
    logic                         serial_clock_in;
    logic                         frame_sync_n;
    logic                         serial_data_in;
    logic                         serial_data_out;
    logic                         device_addr_strap;
    logic                         load_all_n;
    logic                         zero_outputs_n;
    logic [CHANS*SEG_SW-1:0]      seg_switch;
    logic [CHANS*LADDER_BITS-1:0] ladder_switch;
    logic [CHANS*DATA_BITS-1:0]   dac_code;
    int                           fail_count;
    int                           n_compared;
    int                           cycles;
    int                           i;
    logic [15:0]                  prev_word;
    logic [11:0]                  lat [CHANS];
    logic [31:0]                  v;
    logic                         err;

    odsl_loader #(.ADDR_W(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_clock_in(serial_clock_in), .frame_sync_n(frame_sync_n),
        .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
        .device_addr_strap(device_addr_strap), .load_all_n(load_all_n),
        .zero_outputs_n(zero_outputs_n), .seg_switch(seg_switch),
        .ladder_switch(ladder_switch), .dac_code(dac_code));

    odsl_host_model host (.serial_clock_in(serial_clock_in), .frame_sync_n(frame_sync_n),
        .serial_data_in(serial_data_in), .serial_data_out(serial_data_out));

    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Runaway guard, several times the expected length
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 12000)
        begin
            fail_count++;
            final_report;
        end
    end

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic reg_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
        logic [31:0] rd;
        logic        er;
        apb(1'b0, a, 32'h0, rd, er);
        check_val(rd & mask, exp);
    endtask

    task automatic send(input int ch, input logic [11:0] d, input logic a, input int extra);
        logic [15:0] w;
        logic [15:0] echo;
        w = {d, a, 3'(ch)};
        host.send(w, extra, echo);
        check_val(32'(echo), 32'(prev_word));
        prev_word = w;
        repeat (4) @(posedge pclk);
    endtask

    // Checks every converter latch and its switch drive against the model
    task automatic dac_chk(input logic zero);
        int          c;
        logic [11:0] e;
        for (c = 0; c < CHANS; c++)
        begin
            e = zero ? 12'h000 : lat[c];
            check_val(32'(dac_code[12*c +: 12]), 32'(e));
            check_val(32'(ladder_switch[10*c +: 10]), 32'(e[9:0]));
            check_val(32'(seg_switch[3*c +: 3]), 32'(3'h7 >> (2'h3 - e[11:10])));
        end
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        device_addr_strap = 1'b0;
        load_all_n = 1'b1;
        zero_outputs_n = 1'b1;
        fail_count = 0;
        n_compared = 0;
        cycles = 0;
        prev_word = 16'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        reg_chk(OFF_CTRL, 32'hffffffff, 32'h0);
        for (i = 0; i < CHANS; i++)
        begin
            lat[i] = 12'(i * 511 + 165);
            send(i, lat[i], 1'b0, 0);
        end
        for (i = 0; i < CHANS; i++)
            reg_chk(8'h20 + 8'(4 * i), 32'hffffffff, 32'(lat[i]));
        dac_chk(1'b1);
        $display("test serial load done");
        send(0, 12'hfff, 1'b1, 0);
        device_addr_strap <= 1'b1;
        send(2, 12'h123, 1'b0, 0);
        send(3, 12'hc3c, 1'b1, 0);
        lat[3] = 12'hc3c;
        device_addr_strap <= 1'b0;
        send(1, 12'h800, 1'b0, 5);
        lat[1] = 12'h800;
        send(7, 12'h3ff, 1'b0, 0);
        lat[7] = 12'h3ff;
        for (i = 0; i < CHANS; i++)
            reg_chk(8'h20 + 8'(4 * i), 32'hffffffff, 32'(lat[i]));
        $display("test address and overrun done");
        load_all_n <= 1'b0;
        repeat (6) @(posedge pclk);
        load_all_n <= 1'b1;
        repeat (6) @(posedge pclk);
        dac_chk(1'b0);
        zero_outputs_n <= 1'b0;
        repeat (6) @(posedge pclk);
        zero_outputs_n <= 1'b1;
        repeat (6) @(posedge pclk);
        dac_chk(1'b1);
        for (i = 0; i < CHANS; i++)
            reg_chk(8'h20 + 8'(4 * i), 32'hffffffff, 32'(lat[i]));
        load_all_n <= 1'b0;
        repeat (6) @(posedge pclk);
        load_all_n <= 1'b1;
        repeat (6) @(posedge pclk);
        dac_chk(1'b0);
        $display("test load and clear done");
        // Freeze the drain so the two-entry buffer fills and refuses a third word
        apb(1'b1, OFF_CTRL, 32'h1, v, err);
        send(4, 12'haaa, 1'b0, 0);
        send(5, 12'h555, 1'b0, 0);
        send(6, 12'h777, 1'b0, 0);
        reg_chk(8'h30, 32'hffffffff, 32'(lat[4]));
        reg_chk(OFF_STATUS, 32'h00000fff, 32'h0000001b);
        apb(1'b1, OFF_STATUS, 32'h3, v, err);
        apb(1'b1, OFF_CTRL, 32'h0, v, err);
        repeat (6) @(posedge pclk);
        lat[4] = 12'haaa;
        lat[5] = 12'h555;
        for (i = 4; i < 7; i++)
            reg_chk(8'h20 + 8'(4 * i), 32'hffffffff, 32'(lat[i]));
        reg_chk(OFF_STATUS, 32'h00000fff, 32'h00000010);
        apb(1'b1, OFF_CTRL, 32'h2, v, err);
        repeat (6) @(posedge pclk);
        dac_chk(1'b0);
        reg_chk(8'h40 + 8'h14, 32'hffffffff, 32'(lat[5]));
        reg_chk(OFF_COUNT, 32'h0000ffff, 32'h0000000d);
        apb(1'b0, 8'h10, 32'h0, v, err);
        check_val({v[30:0], err}, 32'h1);
        apb(1'b0, 8'h02, 32'h0, v, err);
        check_val({v[30:0], err}, 32'h1);
        $display("test buffer and registers done");
        final_report;
    end
endmodule
